// ### rtl/lble_pkg.sv
// Shared constants, encodings and state type of the ladder bit evaluator
`default_nettype none

package lble_pkg;

  // ----------------------------------------------------------------------
  // Program memory geometry
  // ----------------------------------------------------------------------
  localparam int PM_AW = 15;
  localparam int PM_DW = 16;
  localparam logic [14:0] PM_FIRST = 15'h0000;
  localparam logic [14:0] PM_STEP = 15'h0001;

  // ----------------------------------------------------------------------
  // First-word field positions
  // ----------------------------------------------------------------------
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int AREA_MSB = 11;
  localparam int AREA_LSB = 10;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 0;
  localparam int CNT_MSB = 1;
  localparam int CNT_LSB = 0;

  // ----------------------------------------------------------------------
  // Instruction codes (first word, bits 15..12)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_LOAD_INV = 4'h2;
  localparam logic [3:0] OP_AND = 4'h3;
  localparam logic [3:0] OP_AND_INV = 4'h4;
  localparam logic [3:0] OP_OR = 4'h5;
  localparam logic [3:0] OP_OR_INV = 4'h6;
  localparam logic [3:0] OP_COMB_AND = 4'h7;
  localparam logic [3:0] OP_COMB_OR = 4'h8;
  localparam logic [3:0] OP_OUT = 4'h9;
  localparam logic [3:0] OP_END = 4'ha;
  localparam logic [3:0] OP_OTHER = 4'hb;

  // ----------------------------------------------------------------------
  // Bit operand areas (first word, bits 11..10)
  // ----------------------------------------------------------------------
  localparam logic [1:0] AREA_IO_INTERNAL = 2'h0;
  localparam logic [1:0] AREA_LINK = 2'h1;
  localparam logic [1:0] AREA_HOLDING = 2'h2;
  localparam logic [1:0] AREA_DATA_WORD = 2'h3;

  // ----------------------------------------------------------------------
  // Save buffer and reset values
  // ----------------------------------------------------------------------
  localparam int SAVE_DEPTH = 8;
  localparam logic [3:0] SP_RST = 4'h0;
  localparam logic [3:0] SP_FULL = 4'h8;
  localparam logic [3:0] SP_ONE = 4'h1;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] CNT_LAST = 2'h1;

  typedef enum logic [2:0] {
    ST_START,
    ST_WAIT,
    ST_DECODE,
    ST_EXEC,
    ST_OPND,
    ST_HALT
  } lble_state_t;

endpackage

`default_nettype wire

// ### rtl/lble_cond_unit.sv
// Execution condition and save buffer of the ladder bit evaluator
`timescale 1ns/1ps
`default_nettype none

module lble_cond_unit import lble_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ev_clear,
  input wire logic ev_valid,
  input wire logic [3:0] ev_op,
  input wire logic ev_bit,
  output logic cond_ff,
  output logic [3:0] sp_ff
);

  // ----------------------------------------------------------------------
  // Condition state
  // ----------------------------------------------------------------------
  logic start_ff;
  logic [SAVE_DEPTH-1:0] stack_ff;
  logic nxt_cond;
  logic nxt_start;
  logic [3:0] nxt_sp;
  logic [SAVE_DEPTH-1:0] nxt_stack;
  logic push;
  logic [3:0] sp_dec;
  logic top;

  assign sp_dec = sp_ff - SP_ONE;
  assign top = stack_ff[sp_dec[2:0]];

  // Each step works on the condition left by the step before, no precedence
  always_comb begin
    nxt_cond = cond_ff;
    nxt_start = start_ff;
    nxt_sp = sp_ff;
    push = 1'b0;
    if (ev_clear) begin
      nxt_start = 1'b1;
      nxt_sp = SP_RST;
    end else if (ev_valid) begin
      case (ev_op)
        OP_LOAD, OP_LOAD_INV: begin
          nxt_cond = (ev_op == OP_LOAD) ? ev_bit : ~ev_bit;
          nxt_start = 1'b0;
          if (!start_ff && sp_ff != SP_FULL) begin
            push = 1'b1;
            nxt_sp = sp_ff + SP_ONE;
          end
        end
        // and with operand; chains from leading load
        OP_AND: nxt_cond = cond_ff & ev_bit;
        OP_AND_INV: nxt_cond = cond_ff & ~ev_bit;
        OP_OR: nxt_cond = cond_ff | ev_bit;
        OP_OR_INV: nxt_cond = cond_ff | ~ev_bit;
        OP_COMB_AND, OP_COMB_OR: begin
          if (sp_ff != SP_RST) begin
            nxt_sp = sp_dec;
            nxt_cond = (ev_op == OP_COMB_AND) ? (cond_ff & top)
                                              : (cond_ff | top);
          end
        end
        // A right-hand instruction closes the line
        OP_OUT, OP_OTHER, OP_END: begin
          nxt_start = 1'b1;
          nxt_sp = SP_RST;
        end
        default: nxt_cond = cond_ff;
      endcase
    end
  end

  // One save slot per entry; only the slot at the pointer is written
  genvar gi;
  generate
    for (gi = 0; gi < SAVE_DEPTH; gi++) begin : g_slot
      assign nxt_stack[gi] = (push && sp_ff[2:0] == 3'(gi)) ? cond_ff
                                                              : stack_ff[gi];
    end
  endgenerate

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cond_ff <= 1'b0;
      start_ff <= 1'b1;
      sp_ff <= SP_RST;
      stack_ff <= '0;
    end else begin
      cond_ff <= nxt_cond;
      start_ff <= nxt_start;
      sp_ff <= nxt_sp;
      stack_ff <= nxt_stack;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_load_sets: assert property (@(posedge mclk) disable iff (!rst_b)
    ev_valid && !ev_clear && ev_op == OP_LOAD_INV
    |=> cond_ff == !$past(ev_bit))
    else $error("load-inverted did not set condition");

  a_and_step: assert property (@(posedge mclk) disable iff (!rst_b)
    ev_valid && !ev_clear && ev_op == OP_AND
    |=> cond_ff == ($past(cond_ff) & $past(ev_bit)))
    else $error("and step wrong");

  a_or_inv_step: assert property (@(posedge mclk)
    disable iff (!rst_b)
    ev_valid && !ev_clear && ev_op == OP_OR_INV
    |=> cond_ff == ($past(cond_ff) | !$past(ev_bit)))
    else $error("or-inverted step wrong");

  a_push_depth: assert property (@(posedge mclk) disable iff (!rst_b)
    ev_valid && !ev_clear && ev_op == OP_LOAD && !start_ff && sp_ff < SP_FULL
    |=> sp_ff == $past(sp_ff) + SP_ONE)
    else $error("save buffer not pushed");

endmodule

`default_nettype wire

// ### rtl/lble_ladder_eval.sv
// Top of the ladder bit evaluator: fetch, decode and execution sequencer
//
// What this block does
// - One instruction per address, one to four words including operands.
// - Fetching starts at word zero and runs up to memory capacity.
// - Opcode and any definers come from the first word of an address.
// - A lone bit operand sits in the first word beside the opcode.
// - Later words of an address are operand words, one each.
// - Stored program has one uniform format regardless of loader.
// - Each logic block starts fresh with a load or load-inverted.
// - Load copies its bit; load-inverted copies the bit's complement.
// - And replaces condition with condition AND operand bit.
// - First and after a load uses the value that load produced.
// - And-inverted ANDs condition with complement of operand bit.
// - Or replaces condition with condition OR operand bit.
// - Or-inverted ORs condition with complement of operand bit.
// - Mixed and/or steps run strictly in program order.
// - A later load pushes the condition unless eight are already saved; block combine merges them.
// - Output drives its bit equal to the execution condition.
// - Scan runs to the first end, then restarts at zero.
// - Without any end instruction the program never executes.
`timescale 1ns/1ps
`default_nettype none

module lble_ladder_eval import lble_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  output logic [PM_AW-1:0] pm_addr_ff,
  output logic pm_rd_ff,
  input wire logic [PM_DW-1:0] pm_rdata,
  output logic [1:0] bit_area_ff,
  output logic [9:0] bit_index_ff,
  output logic bit_rd_ff,
  input wire logic bit_rdata,
  output logic bit_wr_ff,
  output logic bit_wdata_ff,
  output logic exec_cond,
  output logic scan_done_ff,
  output logic running_ff,
  output logic halted_ff
);

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  lble_state_t state_ff;
  lble_state_t nxt_state;
  logic [PM_AW-1:0] pc_ff;
  logic [PM_AW-1:0] nxt_pc;
  logic [PM_AW-1:0] nxt_pm_addr;
  logic nxt_pm_rd;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [3:0] op_ff;
  logic [3:0] nxt_op;
  logic [1:0] nxt_bit_area;
  logic [9:0] nxt_bit_index;
  logic nxt_bit_rd;
  logic nxt_bit_wr;
  logic nxt_bit_wdata;
  logic nxt_scan_done;
  logic nxt_running;
  logic nxt_halted;

  // Evaluator handshake
  logic ev_clear;
  logic ev_valid;
  logic [3:0] ev_op;
  logic [3:0] save_sp;

  // ----------------------------------------------------------------------
  // First-word decode
  // ----------------------------------------------------------------------
  logic [3:0] dec_op;
  logic [1:0] dec_cnt;
  logic dec_bit_op;
  logic [15:0] dec_next;
  logic [15:0] dec_len;

  assign dec_op = pm_rdata[OP_MSB:OP_LSB];
  assign dec_cnt = (dec_op == OP_OTHER) ? pm_rdata[CNT_MSB:CNT_LSB] : CNT_RST;
  assign dec_bit_op = (dec_op == OP_LOAD) || (dec_op == OP_LOAD_INV) ||
                      (dec_op == OP_AND) || (dec_op == OP_AND_INV) ||
                      (dec_op == OP_OR) || (dec_op == OP_OR_INV);
  // length is one to four words
  assign dec_len = {14'h0000, dec_cnt} + 16'h0001;
  // Wider sum keeps the carry that marks running past capacity
  assign dec_next = {1'b0, pc_ff} + dec_len;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // A first pass with running_ff low only walks instruction lengths looking
  // for an end; nothing is read or written from the data areas until found.
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_pm_addr = pm_addr_ff;
    nxt_pm_rd = 1'b0;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    nxt_bit_area = bit_area_ff;
    nxt_bit_index = bit_index_ff;
    nxt_bit_rd = 1'b0;
    nxt_bit_wr = 1'b0;
    nxt_bit_wdata = bit_wdata_ff;
    nxt_scan_done = 1'b0;
    nxt_running = running_ff;
    nxt_halted = halted_ff;
    ev_clear = 1'b0;
    ev_valid = 1'b0;
    ev_op = dec_op;
    case (state_ff)
      ST_START: begin
        nxt_pc = PM_FIRST;
        nxt_pm_addr = PM_FIRST;
        nxt_pm_rd = 1'b1;
        ev_clear = 1'b1;
        nxt_state = ST_WAIT;
      end
      // Program word arrives one cycle after the read strobe
      ST_WAIT: nxt_state = ST_DECODE;
      ST_DECODE: begin
        if (dec_op == OP_END) begin
          nxt_scan_done = running_ff;
          nxt_running = 1'b1;
          nxt_pc = PM_FIRST;
          nxt_pm_addr = PM_FIRST;
          nxt_pm_rd = 1'b1;
          ev_clear = 1'b1;
          nxt_state = ST_WAIT;
        end else if (dec_next[15]) begin
          nxt_halted = 1'b1;
          nxt_state = ST_HALT;
        end else if (running_ff && dec_bit_op) begin
          nxt_bit_area = pm_rdata[AREA_MSB:AREA_LSB];
          nxt_bit_index = pm_rdata[BIT_MSB:BIT_LSB];
          nxt_bit_rd = 1'b1;
          nxt_op = dec_op;
          nxt_state = ST_EXEC;
        end else begin
          if (running_ff) begin
            ev_valid = 1'b1;
          end
          if (running_ff && dec_op == OP_OUT) begin
            nxt_bit_area = pm_rdata[AREA_MSB:AREA_LSB];
            nxt_bit_index = pm_rdata[BIT_MSB:BIT_LSB];
            nxt_bit_wr = 1'b1;
            nxt_bit_wdata = exec_cond;
          end
          if (dec_cnt != CNT_RST) begin
            nxt_cnt = dec_cnt;
            nxt_pm_addr = pc_ff + PM_STEP;
            nxt_pm_rd = 1'b1;
            nxt_state = ST_OPND;
          end else begin
            nxt_pc = dec_next[PM_AW-1:0];
            nxt_pm_addr = dec_next[PM_AW-1:0];
            nxt_pm_rd = 1'b1;
            nxt_state = ST_WAIT;
          end
        end
      end
      ST_EXEC: begin
        ev_valid = 1'b1;
        ev_op = op_ff;
        nxt_pc = pc_ff + PM_STEP;
        nxt_pm_addr = pc_ff + PM_STEP;
        nxt_pm_rd = 1'b1;
        nxt_state = ST_WAIT;
      end
      // Operand words are read in order; their data is not needed here
      ST_OPND: begin
        nxt_pm_addr = pm_addr_ff + PM_STEP;
        nxt_pm_rd = 1'b1;
        if (cnt_ff == CNT_LAST) begin
          nxt_pc = pm_addr_ff + PM_STEP;
          nxt_cnt = CNT_RST;
          nxt_state = ST_WAIT;
        end else begin
          nxt_cnt = cnt_ff - CNT_LAST;
        end
      end
      // Only a reset leaves this state
      ST_HALT: nxt_state = ST_HALT;
      default: nxt_state = ST_START;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_START;
      pc_ff <= PM_FIRST;
      pm_addr_ff <= PM_FIRST;
      pm_rd_ff <= 1'b0;
      cnt_ff <= CNT_RST;
      op_ff <= OP_NOP;
      bit_area_ff <= AREA_IO_INTERNAL;
      bit_index_ff <= '0;
      bit_rd_ff <= 1'b0;
      bit_wr_ff <= 1'b0;
      bit_wdata_ff <= 1'b0;
      scan_done_ff <= 1'b0;
      running_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      pm_addr_ff <= nxt_pm_addr;
      pm_rd_ff <= nxt_pm_rd;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      bit_area_ff <= nxt_bit_area;
      bit_index_ff <= nxt_bit_index;
      bit_rd_ff <= nxt_bit_rd;
      bit_wr_ff <= nxt_bit_wr;
      bit_wdata_ff <= nxt_bit_wdata;
      scan_done_ff <= nxt_scan_done;
      running_ff <= nxt_running;
      halted_ff <= nxt_halted;
    end
  end

  // ----------------------------------------------------------------------
  // Execution condition
  // ----------------------------------------------------------------------
  // steps applied in program order
  lble_cond_unit u_cond (
    .mclk(mclk),
    .rst_b(rst_b),
    .ev_clear(ev_clear),
    .ev_valid(ev_valid),
    .ev_op(ev_op),
    .ev_bit(bit_rdata),
    .cond_ff(exec_cond),
    .sp_ff(save_sp)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_end_seen;
    state_ff == ST_DECODE && dec_op == OP_END;
  endsequence

  sequence s_restart;
    pm_rd_ff && pm_addr_ff == PM_FIRST ##1 state_ff == ST_DECODE;
  endsequence

  a_end_restart: assert property (@(posedge mclk)
    disable iff (!rst_b)
    s_end_seen |=> s_restart)
    else $error("scan did not restart at word zero");

  a_out_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    state_ff == ST_DECODE && running_ff && dec_op == OP_OUT
    |=> bit_wr_ff && bit_wdata_ff == $past(exec_cond))
    else $error("output bit not driven from condition");

  a_search_quiet: assert property (@(posedge mclk)
    disable iff (!rst_b)
    !running_ff |-> !bit_wr_ff && !bit_rd_ff && !scan_done_ff)
    else $error("data area touched before an end was found");

  a_bit_exec: assert property (@(posedge mclk) disable iff (!rst_b)
    bit_rd_ff |-> state_ff == ST_EXEC ##1 pm_rd_ff && state_ff == ST_WAIT)
    else $error("bit read not followed by next fetch");

  a_opnd_walk: assert property (@(posedge mclk) disable iff (!rst_b)
    state_ff == ST_OPND
    |-> pm_rd_ff && pm_addr_ff == $past(pm_addr_ff) + PM_STEP)
    else $error("operand words not read in order");

  a_opnd_count: assert property (@(posedge mclk) disable iff (!rst_b)
    state_ff == ST_OPND |-> cnt_ff != CNT_RST)
    else $error("operand walk with no words left");

  // A closed line must not leave saved conditions for the next one
  a_line_clears: assert property (@(posedge mclk)
    disable iff (!rst_b)
    state_ff == ST_DECODE && running_ff && dec_op == OP_OUT
    |=> save_sp == SP_RST)
    else $error("save buffer not cleared at line end");

  a_save_bound: assert property (@(posedge mclk) disable iff (!rst_b)
    save_sp <= SP_FULL)
    else $error("save buffer pointer past its depth");

  a_halt_fetch: assert property (@(posedge mclk) disable iff (!rst_b)
    halted_ff |=> halted_ff && !pm_rd_ff && !bit_wr_ff)
    else $error("fetch or write after halting");

endmodule

`default_nettype wire

// ### sim/lble_mem_model.sv
// Partner model: program memory and data-area bit storage
`timescale 1ns/1ps
`default_nettype none

module lble_mem_model import lble_pkg::*; (
  input wire logic mclk,
  input wire logic [PM_AW-1:0] pm_addr_ff,
  input wire logic pm_rd_ff,
  output logic [PM_DW-1:0] pm_rdata,
  input wire logic [1:0] bit_area_ff,
  input wire logic [9:0] bit_index_ff,
  input wire logic bit_rd_ff,
  output logic bit_rdata,
  input wire logic bit_wr_ff,
  input wire logic bit_wdata_ff
);
  logic [PM_DW-1:0] mem [0:32767];
  logic bits [0:3][0:1023];
  logic junk = 1'b0;

  // ----------------------------------------------------------------
  // Program memory
  // ----------------------------------------------------------------
  // fixed latency read
  // Each idle cycle inverts the held data, so a stale word shows again every second idle cycle
  always @(posedge mclk) begin
    junk <= ~junk;
    if (pm_rd_ff) begin
      pm_rdata <= mem[pm_addr_ff];
    end else begin
      pm_rdata <= ~pm_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Bit storage
  // ----------------------------------------------------------------
  // live bit read
  assign bit_rdata = bit_rd_ff ? bits[bit_area_ff][bit_index_ff] : junk;

  always @(posedge mclk) begin
    if (bit_wr_ff) begin
      bits[bit_area_ff][bit_index_ff] <= bit_wdata_ff;
    end
  end
endmodule
`default_nettype wire

// ### sim/lble_ladder_eval_test.sv
// Self-checking bench for the ladder bit evaluator
`timescale 1ns/1ps
`default_nettype none

module lble_ladder_eval_test import lble_pkg::*;;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [PM_AW-1:0] pm_addr_ff;
  logic pm_rd_ff;
  logic [PM_DW-1:0] pm_rdata;
  logic [1:0] bit_area_ff;
  logic [9:0] bit_index_ff;
  logic bit_rd_ff, bit_rdata, bit_wr_ff, bit_wdata_ff;
  logic exec_cond, scan_done_ff, running_ff, halted_ff;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int bit_ops = 0;
  int trap_hits = 0;
  int n_lines;
  logic exp_bits [0:3][0:1023];
  logic [15:0] prog [$];

  lble_ladder_eval u_dut (.mclk(mclk), .rst_b(rst_b),
    .pm_addr_ff(pm_addr_ff), .pm_rd_ff(pm_rd_ff), .pm_rdata(pm_rdata),
    .bit_area_ff(bit_area_ff), .bit_index_ff(bit_index_ff),
    .bit_rd_ff(bit_rd_ff), .bit_rdata(bit_rdata), .bit_wr_ff(bit_wr_ff),
    .bit_wdata_ff(bit_wdata_ff), .exec_cond(exec_cond),
    .scan_done_ff(scan_done_ff), .running_ff(running_ff),
    .halted_ff(halted_ff));

  lble_mem_model u_mem (.mclk(mclk), .pm_addr_ff(pm_addr_ff),
    .pm_rd_ff(pm_rd_ff), .pm_rdata(pm_rdata), .bit_area_ff(bit_area_ff),
    .bit_index_ff(bit_index_ff), .bit_rd_ff(bit_rd_ff),
    .bit_rdata(bit_rdata), .bit_wr_ff(bit_wr_ff),
    .bit_wdata_ff(bit_wdata_ff));

  // ----------------------------------------------------------------
  // Clock, timeout and bus watch
  // ----------------------------------------------------------------
  // 250 MHz clock
  initial forever #2 mclk = ~mclk;

  // Ceiling well above the longest search pass plus all programs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures++;
      wrap_up();
    end
  end

  // Count bit traffic and writes to the trap bit
  always @(negedge mclk) begin
    if (bit_rd_ff || bit_wr_ff) bit_ops++;
    if (bit_wr_ff && bit_index_ff == 10'h3e8) trap_hits++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic void put(logic [3:0] op, logic [1:0] ar, int ix);
    prog.push_back({op, ar, 10'(ix)});
  endfunction

  // Operand from inputs, or now and then the previous line's output
  function automatic void put_rand(logic [3:0] op, int l);
    if (l > 0 && $urandom % 4 == 0)
      put(op, AREA_HOLDING, 99 + l);
    else
      put(op, 2'($urandom % 4), $urandom % 16);
  endfunction

  function automatic void steps(int l);
    logic [3:0] ops [6] = '{OP_AND, OP_AND_INV, OP_OR, OP_OR_INV,
                            OP_NOP, 4'hc};
    repeat ($urandom % 5) put_rand(ops[$urandom % 6], l);
  endfunction

  // Random lines; operand words of skipped instructions look like outputs
  function automatic void gen(int n);
    int k;
    prog.delete();
    for (int l = 0; l < n; l++) begin
      put_rand(($urandom % 2) ? OP_LOAD : OP_LOAD_INV, l);
      steps(l);
      if ($urandom % 2) begin
        put_rand(($urandom % 2) ? OP_LOAD : OP_LOAD_INV, l);
        steps(l);
        put(($urandom % 2) ? OP_COMB_AND : OP_COMB_OR, 2'h0, 0);
      end
      put(OP_OUT, AREA_HOLDING, 100 + l);
      k = $urandom % 4;
      put(OP_OTHER, 2'h0, k);
      repeat (k) put(OP_OUT, AREA_HOLDING, 1000);
    end
    put(OP_END, 2'h0, 0);
    put(OP_OUT, AREA_HOLDING, 1000);
  endfunction

  // Reference interpreter: one scan over the program image
  function automatic void ref_run();
    int pc = 0;
    int sp = 0;
    logic c = 1'b0;
    logic in_line = 1'b0;
    logic stk [8];
    logic [15:0] w;
    logic b;
    while (prog[pc][15:12] !== OP_END) begin
      w = prog[pc];
      b = exp_bits[w[11:10]][w[9:0]];
      pc++;
      case (w[15:12])
        OP_LOAD, OP_LOAD_INV: begin
          if (in_line && sp < SAVE_DEPTH) begin
            stk[sp] = c;
            sp++;
          end
          c = (w[15:12] == OP_LOAD) ? b : ~b;
          in_line = 1'b1;
        end
        OP_AND: c = c & b;
        OP_AND_INV: c = c & ~b;
        OP_OR: c = c | b;
        OP_OR_INV: c = c | ~b;
        OP_COMB_AND, OP_COMB_OR: begin
          if (sp > 0) begin
            sp--;
            c = (w[15:12] == OP_COMB_AND) ? c & stk[sp] : c | stk[sp];
          end
        end
        OP_OUT: begin
          exp_bits[w[11:10]][w[9:0]] = c;
          sp = 0;
          in_line = 1'b0;
        end
        OP_OTHER: begin
          pc += w[1:0];
          sp = 0;
          in_line = 1'b0;
        end
        default: ;
      endcase
    end
  endfunction

  task automatic rand_bits();
    for (int a = 0; a < 4; a++)
      for (int i = 0; i < 256; i++) u_mem.bits[a][i] = 1'($urandom % 2);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    bit_ops = 0;
    for (int n = 0; n < 8 && pm_rd_ff !== 1'b1; n++) @(negedge mclk);
    check("first read", 16'(pm_rd_ff), 16'h0001);
    check("first fetch", 16'(pm_addr_ff), 16'(PM_FIRST));
  endtask

  task automatic wait_scan();
    @(negedge mclk);
    for (int n = 0; n < 5000 && scan_done_ff !== 1'b1; n++) @(negedge mclk);
    check("scan end", 16'(scan_done_ff), 16'h0001);
  endtask

  task automatic score();
    exp_bits = u_mem.bits;
    ref_run();
    for (int l = 0; l < n_lines; l++)
      check("output bit", 16'(u_mem.bits[2][100 + l]),
            16'(exp_bits[2][100 + l]));
    check("running", 16'(running_ff), 16'h0001);
    check("halted", 16'(halted_ff), 16'h0000);
    check("trap writes", 16'(trap_hits), 16'h0000);
    check("cond", 16'(exec_cond), 16'(exp_bits[2][99 + n_lines]));
  endtask

  task automatic run_prog(int n);
    n_lines = n;
    for (int a = 0; a < 32768; a++)
      u_mem.mem[a] = (a < prog.size()) ? prog[a] : 16'hb003;
    rand_bits();
    do_reset();
    trap_hits = 0;
    wait_scan();
    score();
    rand_bits();
    wait_scan();
    wait_scan();
    score();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(72));
    for (int a = 0; a < 32768; a++) u_mem.mem[a] = 16'hb003;
    do_reset();
    for (int n = 0; n < 45000 && halted_ff !== 1'b1; n++) @(negedge mclk);
    check("halted", 16'(halted_ff), 16'h0001);
    check("running", 16'(running_ff), 16'h0000);
    check("bit traffic", 16'(bit_ops), 16'h0000);
    prog = '{16'h1000, 16'h3001, 16'h50c8, 16'h3002, 16'h4003, 16'h9864,
             16'h2000, 16'h6064, 16'h5400, 16'h9865, 16'h1000, 16'h5001,
             16'h1002, 16'h6003, 16'h7000, 16'h9866, 16'ha000, 16'h9be8};
    run_prog(3);
    // Ten loads in one line overrun the save buffer, then nine merges
    prog.delete();
    repeat (10) put(OP_LOAD, 2'($urandom % 4), $urandom % 16);
    repeat (9) put(($urandom % 2) ? OP_COMB_AND : OP_COMB_OR, 2'h0, 0);
    put(OP_OUT, AREA_HOLDING, 100);
    put(OP_END, 2'h0, 0);
    run_prog(1);
    for (int t = 0; t < 6; t++) begin
      gen(2 + t);
      run_prog(2 + t);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
